// ==== udsu_consts.svh ====
`ifndef UDSU_CONSTS_SVH
`define UDSU_CONSTS_SVH

// Register byte offsets
`define UDSU_REG_CMD 6'h00
`define UDSU_REG_SRC_A 6'h04
`define UDSU_REG_SRC_B 6'h08
`define UDSU_REG_DEST 6'h0C
`define UDSU_REG_EXT 6'h10
`define UDSU_REG_FLAGS 6'h14
`define UDSU_REG_TRAP_PTR 6'h18
`define UDSU_REG_INDEX 6'h1C
`define UDSU_REG_IRQ_STS 6'h20
`define UDSU_REG_IRQ_MSK 6'h24

// Command register fields
`define UDSU_CMD_OPC_LSB 0
`define UDSU_CMD_IMM_LSB 8
`define UDSU_IMM_SEL_BIT 0

// Index and trap pointer fields
`define UDSU_PTR_A_LSB 0
`define UDSU_PTR_B_LSB 8
`define UDSU_PTR_C_LSB 16

// Flag register fields
`define UDSU_FLAG_DIV_BIT 0
`define UDSU_FLAG_NEG_BIT 1

// Interrupt status bits
`define UDSU_IRQ_DONE_BIT 0
`define UDSU_IRQ_TRAP_BIT 1
`define UDSU_IRQ_ILLEGAL_BIT 2
`define UDSU_IRQ_WIDTH 3

// Opcodes, bit 0 of a pair is the immediate select
`define UDSU_OPC_INIT 8'h68
`define UDSU_OPC_STEP 8'h6A
`define UDSU_OPC_LAST 8'h6C
`define UDSU_OPC_REM 8'h6F
`define UDSU_OPC_FULL_DIV 8'hE1

// Reset values
`define UDSU_RST_WORD 32'h0000_0000
`define UDSU_RST_PTR 8'h00
`define UDSU_RST_IRQ 3'h0

`endif

// ==== udsu_pkg.sv ====
`include "udsu_consts.svh"

package udsu_pkg;

    typedef enum logic [2:0] {
        op_none = 3'b000,
        quotient_init_op = 3'b001,
        divide_step_op = 3'b010,
        quotient_final_step_op = 3'b011,
        remainder_fix_op = 3'b100,
        divide_trap_op = 3'b101,
        op_illegal = 3'b110
    } udsu_op_t;

    typedef logic [31:0] udsu_word_t;

    typedef struct packed {
        logic wait_req;
        udsu_word_t rdata;
        logic irq;
        udsu_word_t first_source_operand;
        udsu_word_t second_source_operand;
        udsu_word_t dest;
        udsu_word_t ext;
        logic divide_flag;
        logic negative_flag;
        logic [7:0] idx_a;
        logic [7:0] idx_b;
        logic [7:0] idx_c;
        logic [7:0] trap_operand_ptr_a;
        logic [7:0] trap_operand_ptr_b;
        logic [7:0] trap_operand_ptr_c;
        logic [`UDSU_IRQ_WIDTH-1:0] irq_sts;
        logic [`UDSU_IRQ_WIDTH-1:0] irq_msk;
    } udsu_state_t;

    localparam udsu_state_t UDSU_STATE_RST = '{
        wait_req: 1'b1,
        rdata: `UDSU_RST_WORD,
        irq: 1'b0,
        first_source_operand: `UDSU_RST_WORD,
        second_source_operand: `UDSU_RST_WORD,
        dest: `UDSU_RST_WORD,
        ext: `UDSU_RST_WORD,
        divide_flag: 1'b0,
        negative_flag: 1'b0,
        idx_a: `UDSU_RST_PTR,
        idx_b: `UDSU_RST_PTR,
        idx_c: `UDSU_RST_PTR,
        trap_operand_ptr_a: `UDSU_RST_PTR,
        trap_operand_ptr_b: `UDSU_RST_PTR,
        trap_operand_ptr_c: `UDSU_RST_PTR,
        irq_sts: `UDSU_RST_IRQ,
        irq_msk: `UDSU_RST_IRQ
    };

endpackage

// ==== udsu_alu_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface udsu_alu_if;
    import udsu_pkg::*;
    udsu_op_t kind;
    udsu_word_t src_a;
    udsu_word_t src_b;
    udsu_word_t ext_in;
    logic divide_flag_in;
    logic negative_flag_in;
    udsu_word_t dest_out;
    udsu_word_t ext_out;
    logic divide_flag_out;
    logic negative_flag_out;

    modport core (
        output kind, src_a, src_b, ext_in, divide_flag_in, negative_flag_in,
        input dest_out, ext_out, divide_flag_out, negative_flag_out
    );
    modport alu (
        input kind, src_a, src_b, ext_in, divide_flag_in, negative_flag_in,
        output dest_out, ext_out, divide_flag_out, negative_flag_out
    );
endinterface

`default_nettype wire

// ==== udsu_alu.sv ====
`timescale 1ns/1ps
`default_nettype none

module udsu_alu (
    // Datapath operands and results
    udsu_alu_if.alu dp
);
    import udsu_pkg::*;

    logic [32:0] sum;
    logic carry;
    udsu_word_t res;
    logic new_div;
    logic [63:0] wide;

    always_comb begin
        // Subtract or add by divide flag
        if (dp.divide_flag_in) begin
            sum = {1'b0, dp.src_a} + {1'b0, ~dp.src_b} + 33'h0_0000_0001;
        end else begin
            sum = {1'b0, dp.src_a} + {1'b0, dp.src_b};
        end
        carry = sum[32];
        res = sum[31:0];
        new_div = ~(carry ^ dp.divide_flag_in ^ dp.negative_flag_in);
        wide = 64'h0000_0000_0000_0000;
        dp.dest_out = dp.src_a;
        dp.ext_out = dp.ext_in;
        dp.divide_flag_out = dp.divide_flag_in;
        dp.negative_flag_out = dp.negative_flag_in;
        unique case (dp.kind)
            quotient_init_op: begin
                dp.divide_flag_out = 1'b1;
                dp.negative_flag_out = dp.src_b[31];
                wide = {dp.src_b[30:0], dp.ext_in, 1'b0};
                dp.dest_out = wide[63:32];
                dp.ext_out = wide[31:0];
            end
            divide_step_op: begin
                dp.divide_flag_out = new_div;
                dp.negative_flag_out = res[31];
                wide = {res[30:0], dp.ext_in, new_div};
                dp.dest_out = wide[63:32];
                dp.ext_out = wide[31:0];
            end
            quotient_final_step_op: begin
                dp.divide_flag_out = new_div;
                dp.negative_flag_out = res[31];
                dp.dest_out = res;
                dp.ext_out = {dp.ext_in[30:0], new_div};
            end
            remainder_fix_op: begin
                if (dp.divide_flag_in) begin
                    dp.dest_out = dp.src_a;
                end else begin
                    dp.dest_out = dp.src_a + dp.src_b;
                end
            end
            op_none, divide_trap_op, op_illegal: begin
                dp.dest_out = dp.src_a;
            end
            default: begin
                dp.dest_out = dp.src_a;
            end
        endcase
    end
endmodule

`default_nettype wire

// ==== udsu_top.sv ====
`timescale 1ns/1ps
`default_nettype none

`include "udsu_consts.svh"

module udsu_top (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire udsu_pkg::udsu_word_t avs_writedata,
    output udsu_pkg::udsu_word_t avs_readdata,
    output logic avs_waitrequest,
    // Interrupt
    output logic irq
);
    import udsu_pkg::*;

    udsu_state_t s_q;
    udsu_state_t s_d;
    udsu_alu_if alu_bus ();

    logic wr_fire;
    logic [7:0] cmd_opc;
    logic [7:0] cmd_imm;
    udsu_op_t cmd_kind;
    logic [`UDSU_IRQ_WIDTH-1:0] sts_set;
    logic [`UDSU_IRQ_WIDTH-1:0] sts_clr;
    udsu_word_t wr_word;

    // Byte-lane merge of a write into a register
    function automatic udsu_word_t merge_bytes(
        input udsu_word_t old_val,
        input udsu_word_t new_val,
        input logic [3:0] be
    );
        udsu_word_t r;
        r = old_val;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Opcode to operation class
    function automatic udsu_op_t decode_op(input logic [7:0] opc);
        udsu_op_t k;
        k = op_illegal;
        if ({opc[7:1], 1'b0} == `UDSU_OPC_INIT) begin
            k = quotient_init_op;
        end else if ({opc[7:1], 1'b0} == `UDSU_OPC_STEP) begin
            k = divide_step_op;
        end else if ({opc[7:1], 1'b0} == `UDSU_OPC_LAST) begin
            k = quotient_final_step_op;
        end else if (opc == `UDSU_OPC_REM) begin
            k = remainder_fix_op;
        end else if (opc == `UDSU_OPC_FULL_DIV) begin
            k = divide_trap_op;
        end
        return k;
    endfunction

    udsu_alu u_alu (
        .dp(alu_bus)
    );

    assign wr_fire = avs_write && !s_q.wait_req;
    assign cmd_opc = avs_writedata[`UDSU_CMD_OPC_LSB +: 8];
    assign cmd_imm = avs_writedata[`UDSU_CMD_IMM_LSB +: 8];
    assign cmd_kind = decode_op(cmd_opc);

    // Datapath operand selection
    always_comb begin
        alu_bus.kind = op_none;
        if (wr_fire && avs_address[5:2] == 4'(`UDSU_REG_CMD >> 2)) begin
            alu_bus.kind = cmd_kind;
        end
        alu_bus.src_a = s_q.first_source_operand;
        if (cmd_opc[`UDSU_IMM_SEL_BIT] && cmd_kind != remainder_fix_op) begin
            alu_bus.src_b = {24'h00_0000, cmd_imm};
        end else begin
            alu_bus.src_b = s_q.second_source_operand;
        end
        alu_bus.ext_in = s_q.ext;
        alu_bus.divide_flag_in = s_q.divide_flag;
        alu_bus.negative_flag_in = s_q.negative_flag;
    end

    // Next state
    always_comb begin
        s_d = s_q;
        sts_set = '0;
        sts_clr = '0;
        wr_word = `UDSU_RST_WORD;

        // Bus handshake, one wait state per access
        s_d.wait_req = 1'b1;
        if ((avs_read || avs_write) && s_q.wait_req) begin
            s_d.wait_req = 1'b0;
            if (avs_read) begin
                s_d.rdata = `UDSU_RST_WORD;
                unique case (avs_address[5:2])
                    4'(`UDSU_REG_CMD >> 2): s_d.rdata = `UDSU_RST_WORD;
                    4'(`UDSU_REG_SRC_A >> 2): s_d.rdata = s_q.first_source_operand;
                    4'(`UDSU_REG_SRC_B >> 2): s_d.rdata = s_q.second_source_operand;
                    4'(`UDSU_REG_DEST >> 2): s_d.rdata = s_q.dest;
                    4'(`UDSU_REG_EXT >> 2): s_d.rdata = s_q.ext;
                    4'(`UDSU_REG_FLAGS >> 2): begin
                        s_d.rdata[`UDSU_FLAG_DIV_BIT] = s_q.divide_flag;
                        s_d.rdata[`UDSU_FLAG_NEG_BIT] = s_q.negative_flag;
                    end
                    4'(`UDSU_REG_TRAP_PTR >> 2): begin
                        s_d.rdata[`UDSU_PTR_A_LSB +: 8] = s_q.trap_operand_ptr_a;
                        s_d.rdata[`UDSU_PTR_B_LSB +: 8] = s_q.trap_operand_ptr_b;
                        s_d.rdata[`UDSU_PTR_C_LSB +: 8] = s_q.trap_operand_ptr_c;
                    end
                    4'(`UDSU_REG_INDEX >> 2): begin
                        s_d.rdata[`UDSU_PTR_A_LSB +: 8] = s_q.idx_a;
                        s_d.rdata[`UDSU_PTR_B_LSB +: 8] = s_q.idx_b;
                        s_d.rdata[`UDSU_PTR_C_LSB +: 8] = s_q.idx_c;
                    end
                    4'(`UDSU_REG_IRQ_STS >> 2): begin
                        s_d.rdata[`UDSU_IRQ_WIDTH-1:0] = s_q.irq_sts;
                    end
                    4'(`UDSU_REG_IRQ_MSK >> 2): begin
                        s_d.rdata[`UDSU_IRQ_WIDTH-1:0] = s_q.irq_msk;
                    end
                    default: s_d.rdata = `UDSU_RST_WORD;
                endcase
            end
        end

        // Register writes take effect on the accepting edge
        if (wr_fire) begin
            unique case (avs_address[5:2])
                4'(`UDSU_REG_CMD >> 2): begin
                    if (avs_byteenable[0]) begin
                        unique case (cmd_kind)
                            quotient_init_op, divide_step_op,
                            quotient_final_step_op, remainder_fix_op: begin
                                s_d.dest = alu_bus.dest_out;
                                s_d.ext = alu_bus.ext_out;
                                s_d.divide_flag = alu_bus.divide_flag_out;
                                s_d.negative_flag = alu_bus.negative_flag_out;
                                sts_set[`UDSU_IRQ_DONE_BIT] = 1'b1;
                            end
                            divide_trap_op: begin
                                s_d.trap_operand_ptr_a = s_q.idx_a;
                                s_d.trap_operand_ptr_b = s_q.idx_b;
                                s_d.trap_operand_ptr_c = s_q.idx_c;
                                sts_set[`UDSU_IRQ_TRAP_BIT] = 1'b1;
                            end
                            op_none, op_illegal: begin
                                sts_set[`UDSU_IRQ_ILLEGAL_BIT] = 1'b1;
                            end
                            default: begin
                                sts_set[`UDSU_IRQ_ILLEGAL_BIT] = 1'b1;
                            end
                        endcase
                    end
                end
                4'(`UDSU_REG_SRC_A >> 2): begin
                    s_d.first_source_operand =
                        merge_bytes(s_q.first_source_operand, avs_writedata, avs_byteenable);
                end
                4'(`UDSU_REG_SRC_B >> 2): begin
                    s_d.second_source_operand =
                        merge_bytes(s_q.second_source_operand, avs_writedata, avs_byteenable);
                end
                4'(`UDSU_REG_EXT >> 2): begin
                    s_d.ext = merge_bytes(s_q.ext, avs_writedata, avs_byteenable);
                end
                4'(`UDSU_REG_FLAGS >> 2): begin
                    if (avs_byteenable[0]) begin
                        s_d.divide_flag = avs_writedata[`UDSU_FLAG_DIV_BIT];
                        s_d.negative_flag = avs_writedata[`UDSU_FLAG_NEG_BIT];
                    end
                end
                4'(`UDSU_REG_INDEX >> 2): begin
                    wr_word = merge_bytes({8'h00, s_q.idx_c, s_q.idx_b, s_q.idx_a},
                        avs_writedata, avs_byteenable);
                    s_d.idx_a = wr_word[`UDSU_PTR_A_LSB +: 8];
                    s_d.idx_b = wr_word[`UDSU_PTR_B_LSB +: 8];
                    s_d.idx_c = wr_word[`UDSU_PTR_C_LSB +: 8];
                end
                4'(`UDSU_REG_IRQ_STS >> 2): begin
                    if (avs_byteenable[0]) begin
                        sts_clr = avs_writedata[`UDSU_IRQ_WIDTH-1:0];
                    end
                end
                4'(`UDSU_REG_IRQ_MSK >> 2): begin
                    if (avs_byteenable[0]) begin
                        s_d.irq_msk = avs_writedata[`UDSU_IRQ_WIDTH-1:0];
                    end
                end
                default: begin
                    s_d.dest = s_q.dest;
                end
            endcase
        end

        // Sticky status, set beats clear
        s_d.irq_sts = (s_q.irq_sts & ~sts_clr) | sts_set;
        s_d.irq = |(s_d.irq_sts & s_d.irq_msk);
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_q <= UDSU_STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign avs_readdata = s_q.rdata;
    assign avs_waitrequest = s_q.wait_req;
    assign irq = s_q.irq;

endmodule

`default_nettype wire

// ==== udsu_properties.sv ====
`timescale 1ns/1ps
`default_nettype none

`include "udsu_consts.svh"

module udsu_properties (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire udsu_pkg::udsu_word_t avs_writedata,
    input wire udsu_pkg::udsu_word_t avs_readdata,
    input wire logic avs_waitrequest,
    // Interrupt
    input wire logic irq
);
    import udsu_pkg::*;
    logic acc;
    logic [5:0] wa;
    logic [7:0] last_op_q;
    logic [7:0] last_op_d;
    assign acc = (avs_read || avs_write) && !avs_waitrequest;
    assign wa = {avs_address[5:2], 2'b00};
    // Opcode of the last command taken, forgotten when flags or status are written
    always_comb begin
        last_op_d = last_op_q;
        if (acc && avs_write && wa == `UDSU_REG_CMD && avs_byteenable[0]) begin
            last_op_d = avs_writedata[7:0];
        end else if (acc && avs_write && (wa == `UDSU_REG_FLAGS || wa == `UDSU_REG_IRQ_STS)) begin
            last_op_d = 8'h00;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            last_op_q <= 8'h00;
        end else begin
            last_op_q <= last_op_d;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    property p_wait_answer;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_wait_answer: assert property (p_wait_answer)
        else $error("request not answered after one wait state");
    property p_wait_pulse;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_wait_pulse: assert property (p_wait_pulse)
        else $error("waitrequest low for more than one cycle");
    property p_idle_wait;
        !(avs_read || avs_write) |=> avs_waitrequest;
    endproperty
    a_idle_wait: assert property (p_idle_wait)
        else $error("answer without a request");
    property p_rd_change;
        $changed(avs_readdata) |-> avs_read && !avs_waitrequest;
    endproperty
    a_rd_change: assert property (p_rd_change)
        else $error("read data changed outside a read answer");
    property p_init_df;
        acc && avs_read && wa == `UDSU_REG_FLAGS && last_op_q inside {8'h68, 8'h69}
            |-> avs_readdata[0];
    endproperty
    a_init_df: assert property (p_init_df)
        else $error("divide flag clear after init");
    property p_op_done;
        acc && avs_read && wa == `UDSU_REG_IRQ_STS
            && last_op_q inside {8'h68, 8'h69, 8'h6A, 8'h6B, 8'h6C, 8'h6D, 8'h6F}
            |-> avs_readdata[0];
    endproperty
    a_op_done: assert property (p_op_done)
        else $error("done status missing after datapath op");
    property p_trap_sts;
        acc && avs_read && wa == `UDSU_REG_IRQ_STS && last_op_q == 8'hE1 |-> avs_readdata[1];
    endproperty
    a_trap_sts: assert property (p_trap_sts)
        else $error("trap status missing after full divide");
    property p_irq_cause;
        $rose(irq) |-> $past(avs_write) || $past(avs_write, 2);
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("interrupt rose without a write");
    c_cmd: cover property (acc && avs_write && wa == `UDSU_REG_CMD);
    c_read: cover property (acc && avs_read);
    c_irq: cover property ($rose(irq));
endmodule

bind udsu_top udsu_properties udsu_properties_inst (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .irq(irq)
);

`default_nettype wire

// ==== udsu_bench.sv ====
`timescale 1ns/1ps
`default_nettype none

`include "udsu_consts.svh"

module udsu_bench;
    import udsu_pkg::*;
    logic clk_sys, rst_n, avs_read, avs_write, avs_waitrequest, irq;
    logic [5:0] avs_address;
    logic [3:0] avs_byteenable;
    udsu_word_t avs_writedata, avs_readdata, m_a, m_b, m_ext, m_dest, lo, hi, dv;
    udsu_word_t exp_q[$];
    int errors, check_count;
    logic m_df, m_n;
    logic [2:0] m_sts;

    udsu_top udsu_top_inst (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .irq(irq)
    );

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic chk(input udsu_word_t seen, input udsu_word_t exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("Checks %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // One Avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [5:0] a, input udsu_word_t d,
                       input logic [3:0] be);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        avs_byteenable <= be;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        if (n >= 100) begin
            errors++;
            close_out();
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] a, input udsu_word_t d);
        bus(1'b1, a, d, 4'hF);
    endtask

    task automatic rd(input logic [5:0] a, input udsu_word_t e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0000_0000, 4'hF);
    endtask

    // Read answers compared against the oldest note
    always @(posedge clk_sys) begin
        if (avs_read && avs_waitrequest === 1'b0) begin
            if (exp_q.size() > 0) begin
                chk(avs_readdata, exp_q.pop_front());
            end else begin
                errors++;
                $display("CHECK FAILED at %0t: unexpected read answer", $time);
            end
        end
    end

    // Issue a command, predict its effect, read results back
    task automatic op(input logic [7:0] opc, input logic [7:0] imm);
        udsu_word_t b;
        logic [32:0] s;
        logic ndf;
        b = (opc[0] && opc != `UDSU_OPC_REM) ? {24'h00_0000, imm} : m_b;
        s = m_df ? {1'b0, m_a} + {1'b0, ~b} + 33'h0_0000_0001 : {1'b0, m_a} + {1'b0, b};
        ndf = ~(s[32] ^ m_df ^ m_n);
        wr(`UDSU_REG_CMD, {16'h0000, imm, opc});
        m_sts[0] = 1'b1;
        case (opc[7:1])
            7'h34: begin
                m_df = 1'b1;
                m_n = b[31];
                {m_dest, m_ext} = {b, m_ext} << 1;
            end
            7'h35: {m_dest, m_ext} = {s[30:0], m_ext, ndf};
            7'h36: begin
                m_dest = s[31:0];
                m_ext = {m_ext[30:0], ndf};
            end
            default: m_dest = m_df ? m_a : m_a + b;
        endcase
        if (opc[7:1] == 7'h35 || opc[7:1] == 7'h36) begin
            m_df = ndf;
            m_n = s[31];
        end
        rd(`UDSU_REG_DEST, m_dest);
        if (opc != `UDSU_OPC_REM) begin
            rd(`UDSU_REG_EXT, m_ext);
            rd(`UDSU_REG_FLAGS, {30'h0000_0000, m_n, m_df});
        end
    endtask

    initial begin
        #500_000;
        errors++;
        close_out();
    end

    initial begin
        int t, k;
        {rst_n, avs_read, avs_write, avs_address, avs_byteenable} = '0;
        avs_writedata = 32'h0000_0000;
        {errors, check_count} = '0;
        {m_a, m_b, m_ext, m_dest, m_df, m_n, m_sts} = '0;
        void'($urandom(32'hdf7b));
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        // Reset values, unmapped holes included
        for (k = 0; k < 64; k += 4) begin
            rd(6'(k), 32'h0000_0000);
        end
        wr(6'h28, $urandom);
        rd(6'h28, 32'h0000_0000);
        // Full divide sequences, odd trials on the immediate form
        for (t = 0; t < 4; t++) begin
            dv = t[0] ? 32'($urandom_range(255, 1)) : ($urandom | {t[1], 31'h0000_0000});
            hi = $urandom % dv;
            lo = $urandom;
            m_ext = lo;
            m_b = t[0] ? dv : hi;
            wr(`UDSU_REG_EXT, lo);
            wr(`UDSU_REG_SRC_B, m_b);
            op({7'h34, t[0]}, hi[7:0]);
            m_b = dv;
            wr(`UDSU_REG_SRC_B, dv);
            for (k = 0; k < 32; k++) begin
                m_a = m_dest;
                wr(`UDSU_REG_SRC_A, m_a);
                op({(k == 31) ? 7'h36 : 7'h35, t[0]}, dv[7:0]);
            end
            m_a = m_dest;
            wr(`UDSU_REG_SRC_A, m_a);
            op(`UDSU_OPC_REM, 8'h00);
            rd(`UDSU_REG_IRQ_STS, {29'h0000_0000, m_sts});
        end
        // Byte lanes merge; command without lane 0 ignored
        m_a = $urandom;
        lo = $urandom;
        wr(`UDSU_REG_SRC_A, m_a);
        bus(1'b1, `UDSU_REG_SRC_A, lo, 4'b0011);
        m_a[15:0] = lo[15:0];
        rd(`UDSU_REG_SRC_A, m_a);
        bus(1'b1, `UDSU_REG_CMD, {24'h00_0000, `UDSU_OPC_STEP}, 4'b1110);
        rd(`UDSU_REG_DEST, m_dest);
        // Flags written directly, then one step on the add path
        wr(`UDSU_REG_FLAGS, 32'h0000_0002);
        {m_n, m_df} = 2'b10;
        rd(`UDSU_REG_FLAGS, 32'h0000_0002);
        op(`UDSU_OPC_STEP, 8'h00);
        // Full divide traps with operand pointers, nothing else moves
        lo = $urandom & 32'h00FF_FFFF;
        wr(`UDSU_REG_INDEX, lo);
        wr(`UDSU_REG_CMD, {24'h00_0000, `UDSU_OPC_FULL_DIV});
        m_sts[1] = 1'b1;
        rd(`UDSU_REG_TRAP_PTR, lo);
        rd(`UDSU_REG_INDEX, lo);
        rd(`UDSU_REG_DEST, m_dest);
        rd(`UDSU_REG_EXT, m_ext);
        rd(`UDSU_REG_IRQ_STS, {29'h0000_0000, m_sts});
        // Interrupt raised, masked, cleared
        wr(`UDSU_REG_IRQ_STS, 32'h0000_0007);
        rd(`UDSU_REG_IRQ_STS, 32'h0000_0000);
        wr(`UDSU_REG_IRQ_MSK, 32'h0000_0004);
        rd(`UDSU_REG_IRQ_MSK, 32'h0000_0004);
        wr(`UDSU_REG_CMD, 32'h0000_0070);
        repeat (2) @(posedge clk_sys);
        chk({31'h0000_0000, irq}, 32'h0000_0001);
        wr(`UDSU_REG_IRQ_MSK, 32'h0000_0000);
        repeat (2) @(posedge clk_sys);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        wr(`UDSU_REG_IRQ_MSK, 32'h0000_0004);
        repeat (2) @(posedge clk_sys);
        chk({31'h0000_0000, irq}, 32'h0000_0001);
        wr(`UDSU_REG_IRQ_STS, 32'h0000_0004);
        repeat (2) @(posedge clk_sys);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        repeat (4) @(posedge clk_sys);
        close_out();
    end
endmodule

`default_nettype wire
